// ### bds_params.svh
// Purpose: offsets, field positions and reset values of the demosaic block
// Assumes: 32-bit register bus, byte offsets, one aligned word each
// Notes:   definitions only
`ifndef BDS_PARAMS_SVH
`define BDS_PARAMS_SVH

`define BDS_OFS_CTRL    8'h00
`define BDS_OFS_STAT    8'h04
`define BDS_OFS_WIDTH   8'h08
`define BDS_OFS_HEIGHT  8'h0c
`define BDS_OFS_PHASE   8'h10

`define BDS_CTRL_EN     0
`define BDS_PH_GFIRST   0
`define BDS_PH_BLINE    1

`define BDS_WIDTH_RST   16'h0780
`define BDS_HEIGHT_RST  16'h0438
`define BDS_PHASE_RST   2'h0
`define BDS_MIN_SIZE    16'h0040

`define BDS_RESP_OKAY   2'h0
`define BDS_RESP_SLVERR 2'h2

`endif

// ### bds_pkg.sv
// Purpose: shared types of the demosaic block
// Assumes: register bus with 8-bit byte address and 32-bit data
// Notes:   offsets and reset values live in bds_params.svh
package bds_pkg;

  typedef enum logic {BDS_IDLE, BDS_RUN} bds_mode_t;

  typedef struct packed {
    logic [1:0]  phase;
    logic [15:0] w;
    logic [15:0] h;
  } bds_frame_cfg_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } bds_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bds_axil_rsp_t;

endpackage : bds_pkg

// ### bds_demosaic.sv
// Purpose: bayer demosaic with 5x5 window, video stream in and out
// Assumes: one clock, synchronous active-low reset, width a PPC multiple
// Notes:   settings over axi4-lite, latched at each frame start
`timescale 1ns/1ps
`include "bds_params.svh"

// Contract
// [RULE1] Every pixel leaves with red, green and blue; missing two interpolated.
// [RULE2] Each output pixel uses a 5x5 sample window centred on it.
// [RULE3] Interpolation follows the direction of least colour-difference variation.
// [RULE4] Any of the four bayer phases is selectable.
// [RULE5] Component width 8, 10, 12 or 16 bits, fixed at build time.
// [RULE6] Frames from 64x64 up to 8192x4320 are handled.
// [RULE7] One, two, four or eight pixels per beat, one beat per cycle.
// [RULE8] Without input, output stops once internal data is used up.
// [RULE9] Without output ready, input stops once internal storage is full.
// [RULE10] Input ready held low while flushing at line and frame ends.
// [RULE11] Streams follow axi4-stream video; control follows axi4-lite.
// [RULE12] Start-of-frame user bit on first pixel, one transfer only.
// [RULE13] Last bit on final pixel of every line, one transfer only.
// [RULE14] Low reset clears all logic at the next rising edge; the four line stores lb are not reset.
// [RULE15] Pixel packed green low, then blue, then red; top bits zero.
// [RULE16] Phase, width and height sampled only at frame start.
// [RULE17] Window taps past the frame edge replicate the nearest sample.
module bds_demosaic #(
  // [RULE5] component width
  parameter  int DW    = 10,   // bits per colour component
  parameter  int PPC   = 2,    // pixels per beat
  parameter  int MAX_W = 8192, // widest frame
  parameter  int MAX_H = 4320, // tallest frame
  localparam int IW    = ((DW * PPC + 7) / 8) * 8,
  localparam int OW    = ((3 * DW * PPC + 7) / 8) * 8
) (
  input  logic                   aclk,                // core clock
  input  logic                   aresetn,             // sync reset, low
  input  bds_pkg::bds_axil_req_t axil_req,            // register bus in
  output bds_pkg::bds_axil_rsp_t axil_rsp,            // register bus out
  input  logic [IW-1:0]          s_axis_video_tdata,  // bayer samples
  input  logic                   s_axis_video_tvalid, // input valid
  output logic                   s_axis_video_tready, // input ready
  input  logic                   s_axis_video_tuser,  // input frame start
  input  logic                   s_axis_video_tlast,  // input line end
  output logic [OW-1:0]          m_axis_video_tdata,  // rgb pixels
  output logic                   m_axis_video_tvalid, // output valid
  input  logic                   m_axis_video_tready, // output ready
  output logic                   m_axis_video_tuser,  // output frame start
  output logic                   m_axis_video_tlast   // output line end
);

  localparam int D  = (PPC == 1) ? 2 : 1; // beats of horizontal lag
  localparam int NC = (2 * D + 1) * PPC;  // window columns held
  localparam int WB = MAX_W / PPC;
  localparam int AW = $clog2(WB);
  localparam int SH = $clog2(PPC);

  typedef logic [4:0][DW-1:0] bds_col_t;
  typedef int bds_k_t [5][5];

  typedef struct packed {
    bds_pkg::bds_mode_t      mode;
    logic                    en;
    bds_pkg::bds_frame_cfg_t reg_cfg;
    bds_pkg::bds_frame_cfg_t cfg;
    logic [15:0]             wb;
    logic [15:0]             rin;
    logic [15:0]             bin;
    bds_col_t [NC-1:0]       win;
    logic                    ovalid;
    logic                    ouser;
    logic                    olast;
    logic [OW-1:0]           odata;
    logic                    aw_got;
    logic                    w_got;
    logic [7:0]              awaddr;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } bds_state_t;

  bds_state_t              s;
  bds_state_t              n;
  logic [PPC*DW-1:0]       lb [4][WB];
  logic [3:0][PPC*DW-1:0]  lb_rd;
  logic                    out_free;
  logic                    flushing;
  logic                    start;
  logic                    advance;
  logic                    idle;
  logic [15:0]             cbin;
  logic [15:0]             crin;
  logic [15:0]             cwb;
  bds_pkg::bds_frame_cfg_t ccfg;

  function automatic int iabs(int v);
    return (v < 0) ? -v : v;
  endfunction : iabs

  // round the x16 sum and clip to the component range
  function automatic logic [DW-1:0] sat(int v);
    int t;
    t = (v + 8) >>> 4;
    if (t < 0) t = 0;
    if (t > (1 << DW) - 1) t = (1 << DW) - 1;
    return DW'(t);
  endfunction : sat

  // window tap index after clamping to the frame
  function automatic int tap(int k, int pos, int lim);
    int t;
    t = pos + k - 2;
    if (t < 0) t = 0;
    if (t > lim - 1) t = lim - 1;
    return t - pos + 2;
  endfunction : tap

  function automatic logic [31:0] wm(logic [31:0] o, logic [31:0] v,
                                     logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = v[i*8 +: 8];
    end
    return r;
  endfunction : wm

  // [RULE6] frame size kept in range
  function automatic bds_pkg::bds_frame_cfg_t fitc(
      bds_pkg::bds_frame_cfg_t c);
    bds_pkg::bds_frame_cfg_t r;
    r = c;
    if (r.w < `BDS_MIN_SIZE) r.w = `BDS_MIN_SIZE;
    if (r.w > 16'(MAX_W)) r.w = 16'(MAX_W);
    if (r.h < `BDS_MIN_SIZE) r.h = `BDS_MIN_SIZE;
    if (r.h > 16'(MAX_H)) r.h = 16'(MAX_H);
    r.w = r.w & ~16'(PPC - 1);
    return r;
  endfunction : fitc

  // returns {red, blue, green} for one window
  function automatic logic [3*DW-1:0] interp(bds_k_t a, logic grn,
                                             logic rrow);
    int c, ns, we, nnss, wwee, dg, hc, vc, dc, dh, dv, gr, rr, bb;
    c    = a[2][2];
    ns   = a[1][2] + a[3][2];
    we   = a[2][1] + a[2][3];
    nnss = a[0][2] + a[4][2];
    wwee = a[2][0] + a[2][4];
    dg   = a[1][1] + a[1][3] + a[3][1] + a[3][3];
    // [RULE1] gradient-corrected colour estimates
    hc = 10 * c + 8 * we - 2 * wwee - 2 * dg + nnss;
    vc = 10 * c + 8 * ns - 2 * nnss - 2 * dg + wwee;
    dc = 12 * c + 4 * dg - 3 * (nnss + wwee);
    dh = iabs(a[2][1] - a[2][3]) + iabs(2 * c - wwee);
    dv = iabs(a[1][2] - a[3][2]) + iabs(2 * c - nnss);
    if (grn) begin
      gr = 16 * c;
      rr = rrow ? hc : vc;
      bb = rrow ? vc : hc;
    end else begin
      // [RULE3] pick smoother direction
      gr = 8 * c + 4 * (ns + we) - 2 * (nnss + wwee);
      if (dh < dv) gr = 8 * c + 8 * we - 4 * wwee;
      if (dv < dh) gr = 8 * c + 8 * ns - 4 * nnss;
      rr = rrow ? 16 * c : dc;
      bb = rrow ? dc : 16 * c;
    end
    return {sat(rr), sat(bb), sat(gr)};
  endfunction : interp

  assign idle     = s.mode == bds_pkg::BDS_IDLE;
  assign ccfg     = idle ? fitc(s.reg_cfg) : s.cfg;
  assign cbin     = idle ? 16'h0000 : s.bin;
  assign crin     = idle ? 16'h0000 : s.rin;
  assign cwb      = ccfg.w >> SH;
  assign flushing = (s.bin >= s.wb) || (s.rin >= s.cfg.h);
  // [RULE9] stalled output blocks input
  assign out_free = !s.ovalid || m_axis_video_tready;
  assign start    = idle && s.en && s_axis_video_tvalid &&
                    s_axis_video_tuser;
  // [RULE10] no input while flushing
  assign s_axis_video_tready = s.en && out_free && (idle || !flushing);
  assign advance  = out_free && (start || (!idle &&
                    (flushing || s_axis_video_tvalid)));

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      lb_rd[k] = lb[k][cbin[AW-1:0]];
    end
  end

  // four line stores shift one line down at each write
  always_ff @(posedge aclk) begin
    if (advance && cbin < cwb) begin
      lb[0][cbin[AW-1:0]] <= s_axis_video_tdata[PPC*DW-1:0];
      for (int k = 1; k < 4; k++) begin
        lb[k][cbin[AW-1:0]] <= lb_rd[k-1];
      end
    end
  end

  always_comb begin
    bds_k_t          k5;
    int              y;
    int              x;
    int              rt;
    int              ct;
    logic [3*DW-1:0] rgb;
    k5  = '{default: 0};
    y   = 0;
    x   = 0;
    rt  = 0;
    ct  = 0;
    rgb = '0;
    n   = s;
    // [RULE11] register bus slave
    if (axil_req.awvalid && !s.aw_got) begin
      n.aw_got = 1'b1;
      n.awaddr = axil_req.awaddr;
    end
    if (axil_req.wvalid && !s.w_got) begin
      n.w_got = 1'b1;
      n.wdata = axil_req.wdata;
      n.wstrb = axil_req.wstrb;
    end
    if (s.bvalid && axil_req.bready) n.bvalid = 1'b0;
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = `BDS_RESP_OKAY;
      case (s.awaddr)
        `BDS_OFS_CTRL:   n.en = 1'(wm({31'h0, s.en}, s.wdata,
                                      s.wstrb) >> `BDS_CTRL_EN);
        `BDS_OFS_STAT:   n.bresp = `BDS_RESP_OKAY;
        `BDS_OFS_WIDTH:  n.reg_cfg.w = 16'(wm({16'h0, s.reg_cfg.w}, s.wdata,
                                              s.wstrb));
        `BDS_OFS_HEIGHT: n.reg_cfg.h = 16'(wm({16'h0, s.reg_cfg.h}, s.wdata,
                                              s.wstrb));
        `BDS_OFS_PHASE:  n.reg_cfg.phase = 2'(wm({30'h0, s.reg_cfg.phase},
                                                 s.wdata, s.wstrb));
        default:         n.bresp = `BDS_RESP_SLVERR;
      endcase
    end
    if (s.rvalid && axil_req.rready) n.rvalid = 1'b0;
    if (axil_req.arvalid && !s.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp  = `BDS_RESP_OKAY;
      case (axil_req.araddr)
        `BDS_OFS_CTRL:   n.rdata = {31'h0, s.en};
        `BDS_OFS_STAT:   n.rdata = {s.rin, 14'h0, flushing && !idle, !idle};
        `BDS_OFS_WIDTH:  n.rdata = {16'h0, s.reg_cfg.w};
        `BDS_OFS_HEIGHT: n.rdata = {16'h0, s.reg_cfg.h};
        `BDS_OFS_PHASE:  n.rdata = {30'h0, s.reg_cfg.phase};
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = `BDS_RESP_SLVERR;
        end
      endcase
    end
    // [RULE8] output drains when taken
    if (s.ovalid && m_axis_video_tready) begin
      n.ovalid = 1'b0;
      n.ouser  = 1'b0;
      n.olast  = 1'b0;
    end
    if (advance) begin
      // [RULE16] settings latched at frame start
      if (start) begin
        n.mode = bds_pkg::BDS_RUN;
        n.cfg  = ccfg;
        n.wb   = cwb;
      end
      // [RULE2] shift in new 5-row columns
      for (int p = 0; p < NC - PPC; p++) begin
        n.win[p] = s.win[p+PPC];
      end
      for (int p = 0; p < PPC; p++) begin
        n.win[NC-PPC+p] = {s_axis_video_tdata[p*DW +: DW],
                           lb_rd[0][p*DW +: DW], lb_rd[1][p*DW +: DW],
                           lb_rd[2][p*DW +: DW], lb_rd[3][p*DW +: DW]};
      end
      if (cbin == cwb + 16'(D - 1)) begin
        n.bin = 16'h0000;
        n.rin = crin + 16'h0001;
        if (crin == ccfg.h + 16'h0001) begin
          n.mode = bds_pkg::BDS_IDLE;
          n.rin  = 16'h0000;
        end
      end else begin
        n.bin = cbin + 16'h0001;
      end
      if (crin >= 16'h0002 && cbin >= 16'(D)) begin
        y        = int'(crin) - 2;
        n.ovalid = 1'b1;
        // [RULE12] start marker on first pixel
        n.ouser  = (crin == 16'h0002) && (cbin == 16'(D));
        // [RULE13] line end marker
        n.olast  = cbin == cwb + 16'(D - 1);
        // [RULE7] all lanes in one beat
        for (int p = 0; p < PPC; p++) begin
          x = (int'(cbin) - D) * PPC + p;
          // [RULE17] border taps replicated
          for (int i = 0; i < 5; i++) begin
            for (int j = 0; j < 5; j++) begin
              rt = tap(i, y, int'(ccfg.h));
              ct = tap(j, x, int'(ccfg.w));
              k5[i][j] = int'(n.win[D*PPC+p+ct-2][rt]);
            end
          end
          // [RULE4] phase picks centre colour
          rgb = interp(k5, ccfg.phase[`BDS_PH_GFIRST] ^ x[0] ^ y[0],
                       !ccfg.phase[`BDS_PH_BLINE] ^ y[0]);
          // [RULE15] green low, blue, red
          n.odata[p*3*DW +: 3*DW] = rgb;
        end
      end
    end
    // [RULE14] synchronous clear
    if (!aresetn) begin
      n               = '0;
      n.reg_cfg.w     = `BDS_WIDTH_RST;
      n.reg_cfg.h     = `BDS_HEIGHT_RST;
      n.reg_cfg.phase = `BDS_PHASE_RST;
    end
  end

  always_ff @(posedge aclk) begin
    s <= n;
  end

  assign m_axis_video_tvalid = s.ovalid;
  assign m_axis_video_tdata  = s.odata;
  assign m_axis_video_tuser  = s.ouser;
  assign m_axis_video_tlast  = s.olast;
  assign axil_rsp.awready    = !s.aw_got;
  assign axil_rsp.wready     = !s.w_got;
  assign axil_rsp.bvalid     = s.bvalid;
  assign axil_rsp.bresp      = s.bresp;
  assign axil_rsp.arready    = !s.rvalid;
  assign axil_rsp.rvalid     = s.rvalid;
  assign axil_rsp.rdata      = s.rdata;
  assign axil_rsp.rresp      = s.rresp;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // [RULE11] output held while stalled
  out_hold_a: assert property ( // [RULE11]
    m_axis_video_tvalid && !m_axis_video_tready |=> m_axis_video_tvalid &&
    $stable(m_axis_video_tdata) && $stable(m_axis_video_tuser) &&
    $stable(m_axis_video_tlast))
    else $error("output changed while stalled");
  // [RULE12] single start marker
  sof_once_a: assert property ( // [RULE12]
    m_axis_video_tvalid && m_axis_video_tready && m_axis_video_tuser
    |=> !m_axis_video_tuser [*8])
    else $error("start marker repeated");
  // [RULE13] line end closes the line
  eol_wrap_a: assert property ( // [RULE13]
    m_axis_video_tvalid && m_axis_video_tlast |-> s.bin == 16'h0000)
    else $error("line end not at last beat");
  // [RULE10] flushing refuses input
  flush_ready_a: assert property ( // [RULE10]
    !idle && s.bin >= s.wb |-> !s_axis_video_tready)
    else $error("input ready during flush");
  // [RULE9] stalled output blocks input
  stall_in_a: assert property ( // [RULE9]
    m_axis_video_tvalid && !m_axis_video_tready |-> !s_axis_video_tready)
    else $error("input taken while output stalled");
  // [RULE8] no input means no new output
  drain_out_a: assert property ( // [RULE8]
    !idle && !flushing && !s_axis_video_tvalid && m_axis_video_tready
    |=> !m_axis_video_tvalid)
    else $error("output without input");
  // [RULE7] full rate once the window fills
  beat_rate_a: assert property ( // [RULE7]
    !idle && s.rin >= 16'h0002 && s.bin >= 16'(D) &&
    s_axis_video_tvalid && s_axis_video_tready |=> m_axis_video_tvalid)
    else $error("accepted beat produced no output");
  // [RULE16] settings steady inside a frame
  cfg_stable_a: assert property ( // [RULE16]
    !idle |=> idle || $stable(s.cfg))
    else $error("settings changed mid-frame");
  // [RULE6] latched size within range
  size_range_a: assert property ( // [RULE6]
    !idle |-> s.cfg.w >= `BDS_MIN_SIZE && s.cfg.w <= 16'(MAX_W) &&
    s.cfg.h >= `BDS_MIN_SIZE && s.cfg.h <= 16'(MAX_H))
    else $error("frame size out of range");
  // [RULE15] padding bits stay zero
  pad_zero_a: assert property ( // [RULE15]
    m_axis_video_tvalid |-> (m_axis_video_tdata >> (3 * DW * PPC)) == '0)
    else $error("padding bits not zero");
  // [RULE14] reset clears stream handshakes
  reset_clr_a: assert property ( // [RULE14]
    disable iff (1'b0) !aresetn |=> !m_axis_video_tvalid &&
    !s_axis_video_tready && !axil_rsp.bvalid && !axil_rsp.rvalid)
    else $error("reset left handshakes active");

  sof_out_c: cover property (
    m_axis_video_tvalid && m_axis_video_tready && m_axis_video_tuser);
  eol_out_c: cover property (
    m_axis_video_tvalid && m_axis_video_tready && m_axis_video_tlast);
  stall_c: cover property (m_axis_video_tvalid && !m_axis_video_tready);
  frame_end_c: cover property (!idle ##1 idle);

endmodule : bds_demosaic

// ### bds_peer_model.sv
// Purpose: upstream bayer source and downstream rgb sink for the demosaic
// Assumes: constant colour planes, phase fixed for each frame
// Notes:   released source lines show the inverse of their last value
`timescale 1ns/1ps
module bds_peer_model #(
  parameter  int DW  = 10, // bits per component
  parameter  int PPC = 2,  // pixels per beat
  parameter  int W   = 64, // frame width
  parameter  int H   = 64, // frame height
  localparam int IW  = ((DW * PPC + 7) / 8) * 8
) (
  input  wire logic            aclk,     // core clock
  input  wire logic            aresetn,  // sync reset, low
  input  wire logic            start,    // begin one frame
  input  wire logic            pause,    // hold source valid low
  input  wire logic            stall,    // hold sink ready low
  input  wire logic [2:0]      rnd,      // random throttle bits
  input  wire logic [1:0]      phase,    // bayer phase of frame
  input  wire logic [3*DW-1:0] rgb,      // plane values r, b, g
  input  wire logic            s_tready, // block input ready
  output logic [IW-1:0]        s_tdata,  // bayer samples
  output logic                 s_tvalid, // source valid
  output logic                 s_tuser,  // frame start
  output logic                 s_tlast,  // line end
  output logic                 m_tready  // sink ready
);
  int         x;
  int         y;
  logic       busy;
  logic [1:0] ph;

  function automatic logic [IW-1:0] beat(input int yy, input int bb);
    logic [IW-1:0] d;
    int            xx;
    d = '0;
    for (int p = 0; p < PPC; p++) begin
      xx = bb * PPC + p;
      if (xx[0] ^ yy[0] ^ ph[0])
        d[p*DW +: DW] = rgb[DW-1:0];
      else if (yy[0] ^ ph[1])
        d[p*DW +: DW] = rgb[2*DW-1:DW];
      else
        d[p*DW +: DW] = rgb[3*DW-1:2*DW];
    end
    return d;
  endfunction : beat

  always @(posedge aclk) begin
    m_tready <= !stall && (rnd[0] || rnd[1] || pause);
    if (!aresetn) begin
      busy = 1'b0;
      s_tvalid <= 1'b0;
      s_tdata <= '0;
      s_tuser <= 1'b0;
      s_tlast <= 1'b0;
    end else begin
      if (s_tvalid && s_tready) begin
        x = x + 1;
        if (x == W / PPC) begin
          x = 0;
          y = y + 1;
          busy = (y != H);
        end
      end
      if (start && !busy) begin
        busy = 1'b1;
        x = 0;
        y = 0;
        ph = phase;
      end
      if (!(s_tvalid && !s_tready)) begin
        if (busy && !pause && rnd[2:1] != 2'h0) begin
          s_tvalid <= 1'b1;
          s_tdata <= beat(y, x);
          s_tuser <= (x == 0 && y == 0);
          s_tlast <= (x == W / PPC - 1);
        end else begin
          s_tvalid <= 1'b0;
          s_tdata <= ~s_tdata;
          s_tuser <= ~s_tuser;
          s_tlast <= ~s_tlast;
        end
      end
    end
  end
endmodule : bds_peer_model

// ### bayer_demosaic_stream_bench.sv
// Purpose: self-checking bench of the bayer demosaic stream block
// Assumes: 64x64 frames of constant colour planes, two pixels per beat
// Notes:   border pixels get only marker and padding checks
`timescale 1ns/1ps
`include "bds_params.svh"
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module bayer_demosaic_stream_bench;
  localparam int DW = 10;
  localparam int PPC = 2;
  localparam int W = 64;
  localparam int IW = ((DW * PPC + 7) / 8) * 8;
  localparam int OW = ((3 * DW * PPC + 7) / 8) * 8;
  localparam int PX = 3 * DW * PPC;
  typedef struct packed {
    logic          user;
    logic          last;
    logic [OW-1:0] data;
    logic [OW-1:0] mask;
  } bds_note_t;
  logic aclk, aresetn, s_tvalid, s_tready, s_tuser, s_tlast, eol_seen;
  logic m_tvalid, m_tready, m_tuser, m_tlast, start, pause, stall;
  logic [IW-1:0] s_tdata;
  logic [OW-1:0] m_tdata, held;
  logic [2:0] rnd;
  logic [1:0] ph, bn;
  logic [3*DW-1:0] rgb;
  logic [31:0] seed = 32'h26;
  logic [33:0] rn;
  bds_pkg::bds_axil_req_t req;
  bds_pkg::bds_axil_rsp_t rsp;
  bds_note_t nq[$], gn;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int miscompares = 0;
  int tests_run = 0;

  bds_demosaic #(.DW(DW), .PPC(PPC), .MAX_W(W), .MAX_H(W)) i_bds_demosaic (
    .aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
    .s_axis_video_tdata(s_tdata), .s_axis_video_tvalid(s_tvalid),
    .s_axis_video_tready(s_tready), .s_axis_video_tuser(s_tuser),
    .s_axis_video_tlast(s_tlast), .m_axis_video_tdata(m_tdata),
    .m_axis_video_tvalid(m_tvalid), .m_axis_video_tready(m_tready),
    .m_axis_video_tuser(m_tuser), .m_axis_video_tlast(m_tlast));
  bds_peer_model #(.DW(DW), .PPC(PPC), .W(W), .H(W)) i_bds_peer_model (
    .aclk(aclk), .aresetn(aresetn), .start(start), .pause(pause),
    .stall(stall), .rnd(rnd), .phase(ph), .rgb(rgb), .s_tready(s_tready),
    .s_tdata(s_tdata), .s_tvalid(s_tvalid), .s_tuser(s_tuser),
    .s_tlast(s_tlast), .m_tready(m_tready));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] e);
    bq.push_back(e);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    rq.push_back({d, e});
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
  endtask : axr

  task automatic frame(input logic [1:0] p);
    bds_note_t       n;
    logic [3*DW-1:0] c;
    int              px;
    c = seed[3*DW-1:0];
    for (int yy = 0; yy < W; yy++) begin
      for (int bb = 0; bb < W / PPC; bb++) begin
        n.user = (yy == 0 && bb == 0);
        n.last = (bb == W / PPC - 1);
        n.data = '0;
        n.mask = '0;
        n.mask[OW-1:PX] = '1;
        for (int l = 0; l < PPC; l++) begin
          px = bb * PPC + l;
          if (yy > 1 && yy < W - 2 && px > 1 && px < W - 2) begin
            n.mask[l*3*DW +: 3*DW] = '1;
            n.data[l*3*DW +: 3*DW] = c;
          end
        end
        nq.push_back(n);
      end
    end
    @(posedge aclk);
    ph <= p;
    rgb <= c;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    // return once the frame start beat is taken and settings are latched
    do @(posedge aclk);
    while (!(s_tvalid && s_tready && s_tuser));
  endtask : frame

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end

  always @(posedge aclk) begin
    seed <= xs(seed);
    rnd <= seed[2:0];
    eol_seen <= aresetn && s_tvalid && s_tready && s_tlast;
    if (aresetn) begin
      if (eol_seen) `CHK(s_tready, 1'b0)
      if (m_tvalid && m_tready) begin
        `CHK(nq.size() > 0, 1'b1)
        gn = nq.pop_front();
        `CHK(m_tuser, gn.user)
        `CHK(m_tlast, gn.last)
        `CHK(m_tdata & gn.mask, gn.data)
      end
      if (rsp.bvalid && req.bready) begin
        bn = bq.pop_front();
        `CHK(rsp.bresp, bn)
      end
      if (rsp.rvalid && req.rready) begin
        rn = rq.pop_front();
        `CHK(rsp.rdata, rn[33:2])
        `CHK(rsp.rresp, rn[1:0])
      end
    end
  end

  initial begin
    aresetn = 1'b0;
    req = '0;
    {start, pause, stall, ph, rgb} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`BDS_OFS_CTRL, 32'h0, `BDS_RESP_OKAY);
    axr(`BDS_OFS_WIDTH, {16'h0, `BDS_WIDTH_RST}, `BDS_RESP_OKAY);
    axr(`BDS_OFS_HEIGHT, {16'h0, `BDS_HEIGHT_RST}, `BDS_RESP_OKAY);
    axr(`BDS_OFS_PHASE, {30'h0, `BDS_PHASE_RST}, `BDS_RESP_OKAY);
    axr(`BDS_OFS_STAT, 32'h0, `BDS_RESP_OKAY);
    `CHK(s_tready, 1'b0)
    axw(`BDS_OFS_WIDTH, 32'h1234, 4'h1, `BDS_RESP_OKAY);
    axr(`BDS_OFS_WIDTH, 32'h0734, `BDS_RESP_OKAY);
    axw(8'h14, 32'h1, 4'hf, `BDS_RESP_SLVERR);
    axr(8'h14, 32'h0, `BDS_RESP_SLVERR);
    axw(`BDS_OFS_STAT, 32'hffffffff, 4'hf, `BDS_RESP_OKAY);
    axw(`BDS_OFS_WIDTH, 32'h40, 4'hf, `BDS_RESP_OKAY);
    axw(`BDS_OFS_HEIGHT, 32'h40, 4'hf, `BDS_RESP_OKAY);
    axw(`BDS_OFS_PHASE, 32'h0, 4'hf, `BDS_RESP_OKAY);
    axw(`BDS_OFS_CTRL, 32'h1, 4'hf, `BDS_RESP_OKAY);
    for (int p = 0; p < 4; p++) begin
      frame(p[1:0]);
      axw(`BDS_OFS_PHASE, p + 1, 4'h3, `BDS_RESP_OKAY);
      if (p == 1) axw(`BDS_OFS_WIDTH, 32'h8, 4'hf, `BDS_RESP_OKAY);
      if (p == 2) axw(`BDS_OFS_WIDTH, 32'h40, 4'hf, `BDS_RESP_OKAY);
      if (p == 0) begin
        repeat (600) @(posedge aclk);
        pause <= 1'b1;
        repeat (6) @(negedge aclk);
        repeat (4) begin
          @(negedge aclk);
          `CHK(m_tvalid, 1'b0)
        end
        @(posedge aclk);
        pause <= 1'b0;
        stall <= 1'b1;
        repeat (4) @(negedge aclk);
        while (m_tvalid !== 1'b1) @(negedge aclk);
        held = m_tdata;
        repeat (6) begin
          @(negedge aclk);
          `CHK(s_tready, 1'b0)
          `CHK(m_tdata, held)
        end
        @(posedge aclk);
        stall <= 1'b0;
      end
      while (nq.size() != 0) @(posedge aclk);
    end
    frame(2'h0);
    repeat (300) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(negedge aclk);
    `CHK(m_tvalid, 1'b0)
    `CHK(s_tready, 1'b0)
    nq.delete();
    @(posedge aclk);
    aresetn <= 1'b1;
    axr(`BDS_OFS_WIDTH, {16'h0, `BDS_WIDTH_RST}, `BDS_RESP_OKAY);
    repeat (4) @(posedge aclk);
    wrap_up();
  end
endmodule : bayer_demosaic_stream_bench
